// ---- hw/adc_dev.sv ----
// Purpose: converter end: mode select, conversion timing, serial readout
// Assumes: link pins are asynchronous and pass two flops first
// Notes:   result comes from i_sample, stored at conversion start
// Notes on behaviour
// [R01] serial_in high at start: chip-select mode
// [R02] serial_in low at start: daisy-chain mode
// [R03] optional leading busy bit before data
// [R04] internal counter times conversion; sclk only shifts
// [R05] after conversion: acquire, power down, hold result
// [R06] result is unsigned straight binary, 16 bits
// [R07] host ties serial_in high, start as select
// [R08] start rise: release output, sample, convert
// [R09] conversion ignores later start level
// [R10] no-busy host: start high before minimum time
// [R11] start high at end: no busy, stay released
// [R12] no-busy host waits maximum time before read
// [R13] start fall: drive output with msb
// [R14] next bits on successive sclk falls
// [R15] host may sample either sclk edge
// [R16] no busy: release after 16th fall or start high
// [R17] busy host: start low before minimum time
// [R18] start low at end: drive low busy bit
// [R19] after busy bit, msb first per fall
// [R20] busy: release after 17th fall or start high
// [R21] counter length configurable; sample start at end
`timescale 1ns/1ps
module adc_dev
  import adc_link_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  input  wire logic              i_clock,     // system clock
  input  wire logic              i_sys_rst,   // async reset, high
  adc_link_if.dev                link,        // pins to host
  input  wire logic [DATA_W-1:0] i_sample,    // analog core code
  output logic                   o_chip_sel,  // last mode was chip-select
  output logic                   o_power_dn,  // core powered down
  output logic                   o_busy       // converting
);
  typedef enum logic [3:0] {
    ST_ACQ  = 4'b0001,
    ST_CONV = 4'b0010,
    ST_READ = 4'b0100,
    ST_DONE = 4'b1000
  } dev_st_t;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [1:0] cs_s_q;
  logic [1:0] di_s_q;
  logic [1:0] ck_s_q;
  logic       cs_q;
  logic       ck_q;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // start and sclk idle high: match them so no false edge follows reset
      cs_s_q <= 2'b11;
      di_s_q <= 2'b00;
      ck_s_q <= 2'b11;
      cs_q   <= 1'b1;
      ck_q   <= 1'b1;
    end else begin
      cs_s_q <= {cs_s_q[0], link.convert_start};
      di_s_q <= {di_s_q[0], link.serial_in};
      ck_s_q <= {ck_s_q[0], link.sclk};
      cs_q   <= cs_s_q[1];
      ck_q   <= ck_s_q[1];
    end
  end
  logic cs_rise;
  logic cs_fall;
  logic ck_fall;
  assign cs_rise = cs_s_q[1] && !cs_q;
  assign cs_fall = !cs_s_q[1] && cs_q;
  assign ck_fall = !ck_s_q[1] && ck_q;

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  dev_st_t     st_q;
  logic [5:0]  cnt_q;
  logic [4:0]  bits_q;
  logic        busy_mode_q;
  logic        cs_mode_q;
  logic [DATA_W-1:0] shift_q;
  logic        sdo_q;
  logic        oe_q;
  logic        conv_end;
  // counter length is a parameter so the bench can span min..max
  assign conv_end = (st_q == ST_CONV) && (cnt_q == 6'(CONV_CYCLES - 1)); // [R21]

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q        <= ST_ACQ;
      cnt_q       <= CNT_W0;
      bits_q      <= 5'h00;
      busy_mode_q <= 1'b0;
      cs_mode_q   <= 1'b1;
      shift_q     <= RESULT_RST;
      sdo_q       <= 1'b1;
      oe_q        <= 1'b0;
    end else begin
      case (st_q)
        ST_CONV: begin
          cnt_q <= cnt_q + 6'h01; // [R04] [R09]
          if (conv_end) begin
            cnt_q <= CNT_W0;
            st_q  <= ST_READ; // [R05]
            if (!cs_s_q[1]) begin
              busy_mode_q <= 1'b1; // [R03]
              oe_q        <= 1'b1; // [R18]
              sdo_q       <= 1'b0; // [R18]
            end else begin
              busy_mode_q <= 1'b0; // [R11]
            end
          end
        end
        ST_READ: begin
          if (cs_rise) begin
            oe_q  <= 1'b0; // [R16] [R20]
            st_q  <= ST_CONV; // [R08]
            cs_mode_q <= di_s_q[1]; // [R01] [R02]
            shift_q   <= i_sample; // [R06]
            bits_q    <= 5'h00;
          end else if (!busy_mode_q && cs_fall && bits_q == 5'h00) begin
            oe_q  <= 1'b1; // [R13]
            sdo_q <= shift_q[DATA_W-1]; // [R13]
          end else if (oe_q && ck_fall) begin
            bits_q <= bits_q + 5'h01;
            if (bits_q == (busy_mode_q ? 5'(DATA_W) : 5'(DATA_W - 1))) begin
              oe_q <= 1'b0; // [R16] [R20]
              st_q <= ST_DONE;
            end else if (busy_mode_q && bits_q == 5'h00) begin
              sdo_q <= shift_q[DATA_W-1]; // [R19]
            end else begin
              sdo_q   <= shift_q[DATA_W-2]; // [R14] [R19]
              shift_q <= {shift_q[DATA_W-2:0], 1'b0};
            end
          end
        end
        ST_DONE, ST_ACQ: begin
          if (cs_rise) begin
            oe_q      <= 1'b0; // [R08]
            st_q      <= ST_CONV; // [R08]
            cs_mode_q <= di_s_q[1]; // [R01] [R02]
            shift_q   <= i_sample; // [R06]
            bits_q    <= 5'h00;
          end
        end
        default: st_q <= ST_ACQ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  logic stat_cs_q;
  logic stat_pd_q;
  logic stat_busy_q;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stat_cs_q   <= 1'b1;
      stat_pd_q   <= 1'b1;
      stat_busy_q <= 1'b0;
    end else begin
      stat_cs_q   <= cs_mode_q;
      stat_pd_q   <= (st_q != ST_CONV); // [R05]
      stat_busy_q <= (st_q == ST_CONV);
    end
  end
  assign link.sdo_o  = sdo_q;
  assign link.sdo_oe = oe_q;
  assign o_chip_sel  = stat_cs_q;
  assign o_power_dn  = stat_pd_q;
  assign o_busy      = stat_busy_q;
endmodule : adc_dev

// ---- hw/adc_host.sv ----
// Purpose: host end: starts conversions, reads 3-wire results into a fifo
// Assumes: serial_out synchronised before use
// Notes:   i_busy_mode selects busy-bit variant per conversion
`timescale 1ns/1ps
module adc_host
  import adc_link_pkg::*;
(
  input  wire logic              i_clock,      // system clock
  input  wire logic              i_sys_rst,    // async reset, high
  adc_link_if.host               link,         // pins to converter
  input  wire logic              i_start,      // request one conversion
  input  wire logic              i_busy_mode,  // use busy bit variant
  output logic                   o_idle,       // ready for i_start
  output logic                   o_valid,      // result available
  input  wire logic              i_ready,      // result taken
  output logic [DATA_W-1:0]      o_data        // result word
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_PULSE = 6'b000010,
    H_WAIT = 6'b000100,
    H_IRQ  = 6'b001000,
    H_SHIFT = 6'b010000,
    H_PUSH = 6'b100000
  } host_st_t;

  // ------------------------------------------------------------
  // link
  // ------------------------------------------------------------
  logic [1:0] so_s_q;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) so_s_q <= 2'b11;
    else           so_s_q <= {so_s_q[0], link.serial_out};
  end

  host_st_t          st_q;
  logic [5:0]        cnt_q;
  logic [4:0]        bits_q;
  logic              busy_q;
  logic              cs_q;
  logic              ck_q;
  logic [DATA_W-1:0] rx_q;
  logic              idle_q;
  logic              f_ready;
  logic              f_valid;
  logic [DATA_W-1:0] f_data;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q   <= H_IDLE;
      cnt_q  <= CNT_W0;
      bits_q <= 5'h00;
      busy_q <= 1'b0;
      cs_q   <= 1'b1;
      ck_q   <= 1'b1;
      rx_q   <= RESULT_RST;
      idle_q <= 1'b0;
    end else begin
      idle_q <= (st_q == H_IDLE) && !i_start;
      case (st_q)
        H_IDLE: begin
          if (i_start) begin
            cs_q   <= 1'b0;
            busy_q <= i_busy_mode;
            cnt_q  <= CNT_W0;
            st_q   <= H_PULSE;
          end
        end
        H_PULSE: begin
          cs_q  <= 1'b1; // rising edge starts
          st_q  <= H_WAIT;
          cnt_q <= CNT_W0;
        end
        H_WAIT: begin
          cnt_q <= cnt_q + 6'h01;
          if (busy_q && cnt_q == 6'h02) begin
            cs_q <= 1'b0; // [R17]
          end
          if (cnt_q == 6'(CONV_MAX_CYC + 6)) begin // [R10] [R12] margin for syncs
            cs_q   <= 1'b0;
            cnt_q  <= CNT_W0;
            bits_q <= 5'h00;
            st_q   <= H_IRQ;
          end
        end
        H_IRQ: begin
          cnt_q <= cnt_q + 6'h01;
          // no busy bit: msb needs a full sclk period to cross both ends' syncs
          if (busy_q ? !so_s_q[1] : (cnt_q == 6'(2 * SCLK_HALF_CYC - 1))) begin
            cnt_q <= CNT_W0;
            st_q  <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'(SCLK_HALF_CYC - 1)) begin
            cnt_q <= CNT_W0;
            ck_q  <= !ck_q;
            if (ck_q) begin // falling edge: capture previous bit first [R15]
              if (!(busy_q && bits_q == 5'h00)) rx_q <= {rx_q[DATA_W-2:0], so_s_q[1]};
              bits_q <= bits_q + 5'h01;
              if (bits_q == (busy_q ? 5'(DATA_W) : 5'(DATA_W - 1))) st_q <= H_PUSH;
            end
          end
        end
        H_PUSH: begin
          ck_q <= 1'b1;
          // select stays low: a rise here would start an unrequested conversion
          if (f_ready) begin
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock  (i_clock),
    .i_sys_rst(i_sys_rst),
    .i_valid  (st_q == H_PUSH),
    .o_ready  (f_ready),
    .i_data   (rx_q),
    .o_valid  (f_valid),
    .i_ready  (i_ready),
    .o_data   (f_data)
  );
  assign link.convert_start = cs_q;
  assign link.serial_in     = 1'b1; // [R07]
  assign link.sclk          = ck_q;
  assign o_idle  = idle_q;
  assign o_valid = f_valid;
  assign o_data  = f_data;
endmodule : adc_host

// ---- hw/adc_link_if.sv ----
// Purpose: wires between converter and host
// Assumes: serial_out is open to a pull-up when not driven
// Notes:   level of serial_out resolved here from the enable
`timescale 1ns/1ps
interface adc_link_if;
  logic convert_start;
  logic serial_in;
  logic sclk;
  logic sdo_o;
  logic sdo_oe;
  logic serial_out;
  assign serial_out = sdo_oe ? sdo_o : 1'b1;
  modport dev  (input convert_start, input serial_in, input sclk, output sdo_o, output sdo_oe);
  modport host (output convert_start, output serial_in, output sclk, input serial_out);
endinterface : adc_link_if

// ---- hw/adc_link_pkg.sv ----
// Purpose: shared constants for the converter readout link
// Assumes: 40 MHz system clock on both ends
// Notes:   conversion window 500..930 ns
package adc_link_pkg;
  localparam int unsigned CLK_NS          = 25;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned CONV_MIN_NS     = 500;
  localparam int unsigned CONV_MAX_NS     = 930;
  localparam int unsigned CONV_MIN_CYC    = (CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CONV_MAX_CYC    = CONV_MAX_NS / CLK_NS;
  localparam int unsigned CONV_CYC        = CONV_MAX_CYC - 2;
  localparam int unsigned SCLK_HALF_CYC   = 4;
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam logic [15:0] RESULT_RST      = 16'h0000;
  localparam logic [5:0]  CNT_W0          = 6'h00;
endpackage : adc_link_pkg

// ---- hw/sync_fifo.sv ----
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module sync_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             i_clock,    // system clock
  input  wire logic             i_sys_rst,  // async reset, high
  input  wire logic             i_valid,    // write request
  output logic                  o_ready,    // not full
  input  wire logic [WIDTH-1:0] i_data,     // write data
  output logic                  o_valid,    // not empty
  input  wire logic             i_ready,    // read accept
  output logic      [WIDTH-1:0] o_data      // head word
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  assign o_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign o_valid = wr_q != rd_q;
  assign o_data  = mem[rd_q[AW-1:0]];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
  always_ff @(posedge i_clock) begin
    if (push) mem[wr_q[AW-1:0]] <= i_data;
  end
endmodule : sync_fifo

// ---- tb/adc_link_asserts.sv ----
// Purpose: wire-level checks between converter end and host end
// Assumes: converter sees pin edges 3 cycles late
// Notes:   only link signals are visible here
`timescale 1ns/1ps
module adc_link_asserts (
  input  wire logic i_clock,        // system clock
  input  wire logic i_sys_rst,      // async reset, high
  input  wire logic convert_start,  // start and select
  input  wire logic serial_in,      // mode line
  input  wire logic sclk,           // serial clock
  input  wire logic sdo_o,          // converter data
  input  wire logic sdo_oe,         // converter drives
  input  wire logic serial_out      // resolved wire
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic [4:0] falls_q;
  // --------
  // clock falls while driving
  // --------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) falls_q <= 5'h00;
    else if (!sdo_oe) falls_q <= 5'h00;
    else if ($fell(sclk)) falls_q <= falls_q + 5'h01;
  end
  property p_mode_high;
    serial_in;
  endproperty
  a_mode_high: assert property (p_mode_high) else $error("serial_in dropped");
  property p_rel_conv;
    $rose(convert_start) |-> ##5 (!sdo_oe)[*8];
  endproperty
  a_rel_conv: assert property (p_rel_conv) else $error("output driven in conversion");
  property p_idle_high;
    convert_start[*5] |-> !sdo_oe;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("driven while start high");
  property p_shift_low;
    sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> !sclk;
  endproperty
  a_shift_low: assert property (p_shift_low) else $error("bit changed off clock fall");
  property p_max_falls;
    sdo_oe |-> falls_q <= 5'h11;
  endproperty
  a_max_falls: assert property (p_max_falls) else $error("driven past last fall");
  property p_busy_low;
    $rose(sdo_oe) && !$past(convert_start, 6) |-> !sdo_o;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy bit not low");
  property p_drive_fall;
    $fell(convert_start) ##1 (!convert_start)[*8] |-> ##[0:60] sdo_oe;
  endproperty
  a_drive_fall: assert property (p_drive_fall) else $error("no drive after select");
  // busy host drops select three samples after the rise
  property p_conv_len;
    $rose(convert_start) ##3 !convert_start |-> ##16 !sdo_oe ##[1:40] sdo_oe;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length off");
  c_busy: cover property ($rose(sdo_oe) && !sdo_o);
  c_read: cover property (falls_q == 5'h10);
  c_pull: cover property ($rose(serial_out));
endmodule : adc_link_asserts

// ---- tb/sar_adc_serial_readout_tb.sv ----
// Purpose: both ends joined, results checked through the host fifo
// Assumes: host end keeps serial_in high
// Notes:   second converter end driven by hand in daisy-chain mode
`timescale 1ns/1ps
module sar_adc_serial_readout_tb
  import adc_link_pkg::*;
;
  logic              i_clock   = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic              start     = 1'b0;
  logic              bmode     = 1'b0;
  logic              ready     = 1'b0;
  logic [DATA_W-1:0] sample    = 16'h0000;
  logic [DATA_W-1:0] samp_b    = 16'h0000;
  logic              idle, valid, sel, pdn, busy, sel_b, busy_b;
  logic [DATA_W-1:0] data;
  int                fail_count = 0;
  int                n_compared = 0;
  int                cycles     = 0;
  logic [DATA_W-1:0] tbl [8] = '{16'hA5C3, 16'h0001, 16'hFFFF, 16'h8000,
                                16'h7FFE, 16'h0000, 16'h5A3C, 16'hC001};
  adc_link_if link ();
  adc_link_if link_b ();
  always #12.5 i_clock = ~i_clock;
  adc_dev u_adc_dev (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(link.dev),
    .i_sample(sample), .o_chip_sel(sel), .o_power_dn(pdn), .o_busy(busy));
  adc_dev u_adc_dev_b (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(link_b.dev),
    .i_sample(samp_b), .o_chip_sel(sel_b), .o_power_dn(), .o_busy(busy_b));
  adc_host u_adc_host (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(link.host),
    .i_start(start), .i_busy_mode(bmode), .o_idle(idle), .o_valid(valid),
    .i_ready(ready), .o_data(data));
  adc_link_asserts u_adc_link_asserts (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .convert_start(link.convert_start), .serial_in(link.serial_in), .sclk(link.sclk),
    .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .serial_out(link.serial_out));
  // --------
  // tasks
  // --------
  task automatic chk(input string nm, input logic [DATA_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // no wait when the fifo is known full: the host stalls at the push
  task automatic convert(input logic [DATA_W-1:0] v, input logic bm, input bit wt);
    int n;
    n = 0;
    sample = v;
    bmode = bm;
    start = 1'b1;
    @(negedge i_clock);
    start = 1'b0;
    @(negedge i_clock);
    repeat (6) @(negedge i_clock);
    chk("busy", 16'(busy), 16'h0001);
    chk("power_dn_conv", 16'(pdn), 16'h0000);
    while (wt && idle !== 1'b1 && n < 600) begin
      @(negedge i_clock);
      n++;
    end
    if (wt) begin
      chk("idle", 16'(idle), 16'h0001);
      chk("chip_sel", 16'(sel), 16'h0001);
      chk("power_dn", 16'(pdn), 16'h0001);
    end
  endtask : convert
  task automatic drain(input int first, input int cnt);
    int n;
    for (int k = first; k < first + cnt; k++) begin
      n = 0;
      while (valid !== 1'b1 && n < 600) begin
        @(negedge i_clock);
        n++;
      end
      chk("valid", 16'(valid), 16'h0001);
      chk("data", data, tbl[k]);
      ready = 1'b1;
      @(negedge i_clock);
      ready = 1'b0;
      @(negedge i_clock);
    end
  endtask : drain
  // --------
  // sequence
  // --------
  initial begin
    link_b.convert_start = 1'b1;
    link_b.serial_in = 1'b0;
    link_b.sclk = 1'b1;
    repeat (10) @(negedge i_clock);
    i_sys_rst = 1'b0;
    @(negedge i_clock);
    for (int k = 0; k < 4; k++) convert(tbl[k], k[0], 1'b1);
    convert(tbl[4], 1'b0, 1'b0);
    repeat (300) @(negedge i_clock);
    chk("idle_full", 16'(idle), 16'h0000);
    drain(0, 5);
    for (int k = 5; k < 8; k++) begin
      convert(tbl[k], k[0], 1'b1);
      drain(k, 1);
    end
    samp_b = 16'h1234;
    link_b.convert_start = 1'b0;
    @(negedge i_clock);
    link_b.convert_start = 1'b1;
    repeat (5) @(negedge i_clock);
    chk("chip_sel_b", 16'(sel_b), 16'h0000);
    chk("busy_b", 16'(busy_b), 16'h0001);
    repeat (60) @(negedge i_clock);
    chk("oe_b", 16'(link_b.sdo_oe), 16'h0000);
    wrap_up();
  end
  // a hang counts as a mismatch
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
endmodule : sar_adc_serial_readout_tb
